// File: otp_macro_model.sv
module otp_macro_model #(
    parameter logic [31:0] SEC_VALUE = 32'h0
) (
    input wire logic i_clk,
    input wire otp_sec_pkg::otp_req_s i_req,
    output logic [31:0] o_rdata
);
    timeunit 1ns;
    timeprecision 1ps;
    logic hit1 = 1'b0, hit = 1'b0;
    logic [31:0] word1 = 32'h0, word = 32'h0;
    // Two stages, so the answer stands in the cycle the loader takes it
    always @(posedge i_clk)
    begin
        hit1 <= i_req.re;
        word1 <= (i_req.addr == otp_sec_pkg::SEC_ROW) ? SEC_VALUE : {20'h0, i_req.addr};
        hit <= hit1;
        word <= word1;
    end
    // Inverted outside the answer cycle so a late sample cannot pass
    assign o_rdata = hit ? word : ~word;
endmodule : otp_macro_model

// File: otp_sec_pkg.sv
package otp_sec_pkg;

    // ----------------------------------------
    // OTP organisation
    // ----------------------------------------
    localparam int OTP_SECTORS = 4;
    localparam int OTP_ROWS = 512;
    localparam int OTP_AW = 11;
    localparam int MACRO_AW = 12;
    localparam logic [MACRO_AW-1:0] SEC_ROW = 12'h800;
    localparam logic [OTP_AW-1:0] OTP_LAST = 11'h7ff;
    localparam int SECT_LSB = 9;
    localparam int RD_LAT = 2;

    // ----------------------------------------
    // Programming port identifiers
    // ----------------------------------------
    localparam logic [23:0] PORT_ID_ADDR = 24'h100200;
    localparam logic [23:0] PORT_ID_DATA = 24'h200100;
    localparam logic [23:0] PORT_ID_CTRL = 24'h100300;
    localparam int CTRL_GO = 0;
    localparam int CTRL_SEC = 1;

    // ----------------------------------------
    // Test access port
    // ----------------------------------------
    localparam int IR_W = 4;
    localparam int DR_W = 32;
    localparam logic [IR_W-1:0] IR_CAPTURE = 4'h1;
    localparam logic [IR_W-1:0] IR_SCAN_IDENTIFICATION = 4'h1;
    localparam logic [IR_W-1:0] IR_USERCODE = 4'h2;
    localparam logic [IR_W-1:0] IR_OTP_ADDR = 4'h3;
    localparam logic [IR_W-1:0] IR_OTP_DATA = 4'h4;
    localparam logic [IR_W-1:0] IR_DEBUG = 4'h5;
    localparam logic [IR_W-1:0] IR_BYPASS = 4'hf;
    // Identity values are arbitrary
    localparam logic [3:0] ID_VERSION = 4'h0;
    localparam logic [15:0] ID_PART = 16'h0a5c;
    localparam logic [10:0] ID_MAKER = 11'h2aa;
    localparam logic [7:0] SILICON_REV = 8'h01;

    // Locked-down word held until the real one is loaded
    localparam logic [31:0] SEC_SAFE = 32'h0000_7003;

    typedef struct packed {
        logic [9:0] user_id;
        logic [6:0] gp;
        logic dbg_pin_off;
        logic scan_otp_off;
        logic master_lock;
        logic [OTP_SECTORS-1:0] sector_lock;
        logic redundant;
        logic rsv6;
        logic boot_otp;
        logic [2:0] rsv4_2;
        logic link_off;
        logic scan_off;
    } sec_s;

    typedef struct packed {
        logic re;
        logic we;
        logic [MACRO_AW-1:0] addr;
        logic [31:0] wdata;
    } otp_req_s;

    typedef enum logic [15:0] {
        T_RESET = 16'h0001, T_IDLE = 16'h0002, T_SEL_DR = 16'h0004, T_CAP_DR = 16'h0008,
        T_SH_DR = 16'h0010, T_EX1_DR = 16'h0020, T_PA_DR = 16'h0040, T_EX2_DR = 16'h0080,
        T_UP_DR = 16'h0100, T_SEL_IR = 16'h0200, T_CAP_IR = 16'h0400, T_SH_IR = 16'h0800,
        T_EX1_IR = 16'h1000, T_PA_IR = 16'h2000, T_EX2_IR = 16'h4000, T_UP_IR = 16'h8000
    } tap_e;

    typedef enum logic [3:0] {
        B_LOAD = 4'h1, B_COPY = 4'h2, B_DRAIN = 4'h4, B_RUN = 4'h8
    } boot_e;

endpackage : otp_sec_pkg

// File: otp_security_and_id.sv
// Contract
// - Security bit 0 blocks all scan-port debug access
// - Security bit 1 blocks switch access to processor
// - Security bit 5 boots from OTP address zero
// - Security bit 7 enables redundant OTP rows
// - Bits 8-11 lock programming of sectors 0-3
// - Bit 12 rejects every OTP programming attempt
// - Bit 13 denies scan-port OTP reads and writes
// - Bit 14 disables the debug sync pin
// - Bits 15-21 are plain software bits
// - Bits 22-31 extend the user code field
// - Four sectors of 512 32-bit rows
// - Security word loads from OTP at power up
// - Remaining OTP copied to SRAM at start
// - Three programming ports with fixed identifiers
// - Test port has 4-bit IR, 32-bit DR
// - Output-mode sync pin driven low on breakpoint
// - Input-mode sync pin low enters debug mode
// - SCAN_IDENTIFICATION returns version, part and maker fields
// - USERCODE holds user id above silicon revision
module otp_security_and_id (
    input wire logic i_clk,
    input wire logic i_nrst,
    input wire logic i_tck,
    input wire logic i_tms,
    input wire logic i_tdi,
    input wire logic i_trst_n,
    output logic o_tdo,
    output logic o_tdo_oe,
    output otp_sec_pkg::otp_req_s o_otp,
    input wire logic [31:0] i_otp_rdata,
    output logic o_sram_we,
    output logic [otp_sec_pkg::OTP_AW-1:0] o_sram_addr,
    output logic [31:0] o_sram_wdata,
    output logic o_boot_done,
    output logic o_boot_from_otp,
    output logic o_otp_redundant,
    output logic [31:0] o_sec_word,
    input wire logic i_port_we,
    input wire logic [23:0] i_port_id,
    input wire logic [31:0] i_port_wdata,
    output logic o_prog_reject,
    input wire logic i_link_dbg_req,
    output logic o_link_dbg_grant,
    input wire logic [31:0] i_dbg_rdata,
    output logic [31:0] o_dbg_wdata,
    output logic o_dbg_we,
    input wire logic i_dbg_pin,
    output logic o_dbg_pin,
    output logic o_dbg_pin_oe,
    input wire logic i_dbg_pin_out_mode,
    input wire logic i_breakpoint,
    input wire logic i_dbg_resume,
    output logic o_debug_enter
);

    // ----------------------------------------
    // Pin synchronisers
    // ----------------------------------------
    logic [4:0] pin_s1;
    logic [4:0] pin_s2;
    logic tck_d;
    always_ff @(posedge i_clk or negedge i_nrst)
    begin
        if (!i_nrst)
        begin
            // Sync pin idles high, so no false edge follows reset
            pin_s1 <= 5'h10;
            pin_s2 <= 5'h10;
            tck_d <= 1'b0;
        end
        else
        begin
            pin_s1 <= {i_dbg_pin, i_trst_n, i_tdi, i_tms, i_tck};
            pin_s2 <= pin_s1;
            tck_d <= pin_s2[0];
        end
    end
    logic tck_rise;
    logic tck_fall;
    assign tck_rise = pin_s2[0] & ~tck_d;
    assign tck_fall = ~pin_s2[0] & tck_d;

    // ----------------------------------------
    // Shared state
    // ----------------------------------------
    otp_sec_pkg::sec_s sec;
    otp_sec_pkg::tap_e tap;
    otp_sec_pkg::tap_e next_tap;
    logic [otp_sec_pkg::IR_W-1:0] ir, next_ir, ir_sr, next_ir_sr;
    logic [otp_sec_pkg::DR_W-1:0] dr, next_dr;
    logic [otp_sec_pkg::OTP_AW:0] jt_addr, next_jt_addr;
    logic [31:0] jt_rdata;
    logic jt_rd, next_jt_rd, jt_wr, next_jt_wr;
    logic next_tdo, next_tdo_oe, next_dbg_we;
    logic [31:0] next_dbg_wdata;

    function automatic logic prog_locked(otp_sec_pkg::sec_s s, logic to_sec,
                                         logic [otp_sec_pkg::OTP_AW-1:0] a);
        logic hit;
        hit = s.master_lock;
        if (!to_sec)
        begin
            hit = hit | s.sector_lock[a[otp_sec_pkg::OTP_AW-1:otp_sec_pkg::SECT_LSB]];
        end
        return hit;
    endfunction : prog_locked

    // ----------------------------------------
    // Test access port, stepped on sampled clock edges
    // ----------------------------------------
    always_comb
    begin
        next_tap = tap;
        next_ir = ir;
        next_ir_sr = ir_sr;
        next_dr = dr;
        next_jt_addr = jt_addr;
        next_jt_rd = 1'b0;
        next_jt_wr = 1'b0;
        next_tdo = o_tdo;
        next_tdo_oe = o_tdo_oe;
        next_dbg_we = 1'b0;
        next_dbg_wdata = o_dbg_wdata;
        if (!pin_s2[3])
        begin
            next_tap = otp_sec_pkg::T_RESET;
            next_ir = otp_sec_pkg::IR_SCAN_IDENTIFICATION;
            next_tdo_oe = 1'b0;
        end
        else if (tck_rise)
        begin
            case (tap)
                otp_sec_pkg::T_RESET: next_tap = pin_s2[1] ? otp_sec_pkg::T_RESET : otp_sec_pkg::T_IDLE;
                otp_sec_pkg::T_IDLE: next_tap = pin_s2[1] ? otp_sec_pkg::T_SEL_DR : otp_sec_pkg::T_IDLE;
                otp_sec_pkg::T_SEL_DR: next_tap = pin_s2[1] ? otp_sec_pkg::T_SEL_IR : otp_sec_pkg::T_CAP_DR;
                otp_sec_pkg::T_CAP_DR: next_tap = pin_s2[1] ? otp_sec_pkg::T_EX1_DR : otp_sec_pkg::T_SH_DR;
                otp_sec_pkg::T_SH_DR: next_tap = pin_s2[1] ? otp_sec_pkg::T_EX1_DR : otp_sec_pkg::T_SH_DR;
                otp_sec_pkg::T_EX1_DR: next_tap = pin_s2[1] ? otp_sec_pkg::T_UP_DR : otp_sec_pkg::T_PA_DR;
                otp_sec_pkg::T_PA_DR: next_tap = pin_s2[1] ? otp_sec_pkg::T_EX2_DR : otp_sec_pkg::T_PA_DR;
                otp_sec_pkg::T_EX2_DR: next_tap = pin_s2[1] ? otp_sec_pkg::T_UP_DR : otp_sec_pkg::T_SH_DR;
                otp_sec_pkg::T_SEL_IR: next_tap = pin_s2[1] ? otp_sec_pkg::T_RESET : otp_sec_pkg::T_CAP_IR;
                otp_sec_pkg::T_CAP_IR: next_tap = pin_s2[1] ? otp_sec_pkg::T_EX1_IR : otp_sec_pkg::T_SH_IR;
                otp_sec_pkg::T_SH_IR: next_tap = pin_s2[1] ? otp_sec_pkg::T_EX1_IR : otp_sec_pkg::T_SH_IR;
                otp_sec_pkg::T_EX1_IR: next_tap = pin_s2[1] ? otp_sec_pkg::T_UP_IR : otp_sec_pkg::T_PA_IR;
                otp_sec_pkg::T_PA_IR: next_tap = pin_s2[1] ? otp_sec_pkg::T_EX2_IR : otp_sec_pkg::T_PA_IR;
                otp_sec_pkg::T_EX2_IR: next_tap = pin_s2[1] ? otp_sec_pkg::T_UP_IR : otp_sec_pkg::T_SH_IR;
                default: next_tap = pin_s2[1] ? otp_sec_pkg::T_SEL_DR : otp_sec_pkg::T_IDLE;
            endcase
            case (tap)
                otp_sec_pkg::T_RESET: next_ir = otp_sec_pkg::IR_SCAN_IDENTIFICATION;
                otp_sec_pkg::T_CAP_IR: next_ir_sr = otp_sec_pkg::IR_CAPTURE;
                otp_sec_pkg::T_SH_IR: next_ir_sr = {pin_s2[2], ir_sr[otp_sec_pkg::IR_W-1:1]};
                otp_sec_pkg::T_UP_IR: next_ir = ir_sr;
                otp_sec_pkg::T_CAP_DR:
                begin
                    case (ir)
                        otp_sec_pkg::IR_SCAN_IDENTIFICATION: next_dr = {otp_sec_pkg::ID_VERSION,
                            otp_sec_pkg::ID_PART, otp_sec_pkg::ID_MAKER, 1'b1};
                        otp_sec_pkg::IR_USERCODE: next_dr = {sec.user_id, 14'h0000,
                            otp_sec_pkg::SILICON_REV};
                        // Denied reads capture zero so nothing leaks
                        otp_sec_pkg::IR_OTP_DATA: next_dr = (sec.scan_otp_off | sec.scan_off) ?
                            32'h0000_0000 : jt_rdata;
                        otp_sec_pkg::IR_DEBUG: next_dr = sec.scan_off ? 32'h0000_0000 : i_dbg_rdata;
                        default: next_dr = 32'h0000_0000;
                    endcase
                end
                otp_sec_pkg::T_SH_DR:
                begin
                    if (ir == otp_sec_pkg::IR_BYPASS || ir[3] == 1'b1)
                    begin
                        next_dr[0] = pin_s2[2];
                    end
                    else
                    begin
                        next_dr = {pin_s2[2], dr[otp_sec_pkg::DR_W-1:1]};
                    end
                end
                otp_sec_pkg::T_UP_DR:
                begin
                    if (ir == otp_sec_pkg::IR_OTP_ADDR && !sec.scan_otp_off && !sec.scan_off)
                    begin
                        next_jt_addr = dr[otp_sec_pkg::OTP_AW:0];
                        next_jt_rd = 1'b1;
                    end
                    if (ir == otp_sec_pkg::IR_OTP_DATA && !sec.scan_otp_off && !sec.scan_off)
                    begin
                        next_jt_wr = 1'b1;
                    end
                    if (ir == otp_sec_pkg::IR_DEBUG && !sec.scan_off)
                    begin
                        next_dbg_we = 1'b1;
                        next_dbg_wdata = dr;
                    end
                end
                default: next_ir = ir;
            endcase
        end
        else if (tck_fall)
        begin
            next_tdo_oe = (tap == otp_sec_pkg::T_SH_DR) || (tap == otp_sec_pkg::T_SH_IR);
            next_tdo = (tap == otp_sec_pkg::T_SH_IR) ? ir_sr[0] : dr[0];
        end
    end

    always_ff @(posedge i_clk or negedge i_nrst)
    begin
        if (!i_nrst)
        begin
            tap <= otp_sec_pkg::T_RESET;
            ir <= otp_sec_pkg::IR_SCAN_IDENTIFICATION;
            ir_sr <= otp_sec_pkg::IR_CAPTURE;
            dr <= 32'h0000_0000;
            jt_addr <= 12'h000;
            jt_rd <= 1'b0;
            jt_wr <= 1'b0;
            o_tdo <= 1'b0;
            o_tdo_oe <= 1'b0;
            o_dbg_we <= 1'b0;
            o_dbg_wdata <= 32'h0000_0000;
        end
        else
        begin
            tap <= next_tap;
            ir <= next_ir;
            ir_sr <= next_ir_sr;
            dr <= next_dr;
            jt_addr <= next_jt_addr;
            jt_rd <= next_jt_rd;
            jt_wr <= next_jt_wr;
            o_tdo <= next_tdo;
            o_tdo_oe <= next_tdo_oe;
            o_dbg_we <= next_dbg_we;
            o_dbg_wdata <= next_dbg_wdata;
        end
    end

    // ----------------------------------------
    // Boot loader, programming and pin gating
    // ----------------------------------------
    otp_sec_pkg::boot_e boot, next_boot;
    otp_sec_pkg::sec_s next_sec;
    otp_sec_pkg::otp_req_s next_otp;
    logic [otp_sec_pkg::OTP_AW-1:0] cp_addr, next_cp_addr;
    logic [otp_sec_pkg::OTP_AW-1:0] prog_addr, next_prog_addr;
    logic [31:0] prog_data, next_prog_data, next_jt_rdata;
    logic [otp_sec_pkg::RD_LAT-1:0] rd_v, rd_cp;
    logic [otp_sec_pkg::OTP_AW-1:0] rd_a [otp_sec_pkg::RD_LAT];
    logic jt_pend, next_jt_pend, jt_pw, next_jt_pw;
    logic next_sram_we, next_reject, next_grant, next_pin_oe, next_enter, bp_hold, next_bp_hold;
    logic [otp_sec_pkg::OTP_AW-1:0] next_sram_addr;
    logic [31:0] next_sram_wdata;
    logic pin_d;

    always_comb
    begin
        next_boot = boot;
        next_sec = sec;
        next_otp = '0;
        next_cp_addr = cp_addr;
        next_prog_addr = prog_addr;
        next_prog_data = prog_data;
        next_jt_rdata = jt_rdata;
        next_jt_pend = jt_pend | jt_rd | jt_wr;
        next_jt_pw = (jt_rd | jt_wr) ? jt_wr : jt_pw;
        next_sram_we = 1'b0;
        next_sram_addr = o_sram_addr;
        next_sram_wdata = o_sram_wdata;
        next_reject = 1'b0;
        // Returned OTP words land by the tag they were issued with
        if (rd_v[otp_sec_pkg::RD_LAT-1])
        begin
            if (boot == otp_sec_pkg::B_LOAD)
            begin
                next_sec = i_otp_rdata;
                next_boot = otp_sec_pkg::B_COPY;
            end
            else if (rd_cp[otp_sec_pkg::RD_LAT-1])
            begin
                next_sram_we = 1'b1;
                next_sram_addr = rd_a[otp_sec_pkg::RD_LAT-1];
                next_sram_wdata = i_otp_rdata;
            end
            else
            begin
                next_jt_rdata = i_otp_rdata;
            end
        end
        case (boot)
            otp_sec_pkg::B_LOAD:
            begin
                next_otp.re = (rd_v == '0) && !rd_v[otp_sec_pkg::RD_LAT-1];
                next_otp.addr = otp_sec_pkg::SEC_ROW;
            end
            otp_sec_pkg::B_COPY:
            begin
                next_otp.re = 1'b1;
                next_otp.addr = {1'b0, cp_addr};
                next_cp_addr = cp_addr + 11'h001;
                if (cp_addr == otp_sec_pkg::OTP_LAST)
                begin
                    next_boot = otp_sec_pkg::B_DRAIN;
                end
            end
            otp_sec_pkg::B_DRAIN:
            begin
                if (rd_v == '0)
                begin
                    next_boot = otp_sec_pkg::B_RUN;
                end
            end
            otp_sec_pkg::B_RUN:
            begin
                if (i_port_we && i_port_id == otp_sec_pkg::PORT_ID_ADDR)
                begin
                    next_prog_addr = i_port_wdata[otp_sec_pkg::OTP_AW-1:0];
                end
                if (i_port_we && i_port_id == otp_sec_pkg::PORT_ID_DATA)
                begin
                    next_prog_data = i_port_wdata;
                end
                if (i_port_we && i_port_id == otp_sec_pkg::PORT_ID_CTRL && i_port_wdata[otp_sec_pkg::CTRL_GO])
                begin
                    if (prog_locked(sec, i_port_wdata[otp_sec_pkg::CTRL_SEC], prog_addr))
                    begin
                        next_reject = 1'b1;
                    end
                    else
                    begin
                        next_otp.we = 1'b1;
                        next_otp.addr = i_port_wdata[otp_sec_pkg::CTRL_SEC] ?
                            otp_sec_pkg::SEC_ROW : {1'b0, prog_addr};
                        next_otp.wdata = prog_data;
                        if (i_port_wdata[otp_sec_pkg::CTRL_SEC])
                        begin
                            next_sec = sec | prog_data;
                        end
                    end
                end
                else if (jt_pend)
                begin
                    next_jt_pend = jt_rd | jt_wr;
                    next_otp.addr = jt_addr[otp_sec_pkg::OTP_AW] ?
                        otp_sec_pkg::SEC_ROW : {1'b0, jt_addr[otp_sec_pkg::OTP_AW-1:0]};
                    next_otp.wdata = dr;
                    if (!jt_pw)
                    begin
                        next_otp.re = 1'b1;
                    end
                    else if (prog_locked(sec, jt_addr[otp_sec_pkg::OTP_AW],
                                         jt_addr[otp_sec_pkg::OTP_AW-1:0]))
                    begin
                        next_reject = 1'b1;
                    end
                    else
                    begin
                        next_otp.we = 1'b1;
                        if (jt_addr[otp_sec_pkg::OTP_AW])
                        begin
                            next_sec = sec | dr;
                        end
                    end
                end
            end
            default: next_boot = otp_sec_pkg::B_LOAD;
        endcase
        next_grant = i_link_dbg_req & ~sec.link_off & (boot == otp_sec_pkg::B_RUN);
        next_bp_hold = (bp_hold | i_breakpoint) & ~i_dbg_resume;
        // Pin is only ever pulled low, never driven high
        next_pin_oe = next_bp_hold & i_dbg_pin_out_mode & ~sec.dbg_pin_off;
        next_enter = ~i_dbg_pin_out_mode & ~sec.dbg_pin_off & pin_d & ~pin_s2[4];
    end

    always_ff @(posedge i_clk or negedge i_nrst)
    begin
        if (!i_nrst)
        begin
            boot <= otp_sec_pkg::B_LOAD;
            sec <= otp_sec_pkg::SEC_SAFE;
            o_otp <= '0;
            cp_addr <= 11'h000;
            prog_addr <= 11'h000;
            prog_data <= 32'h0000_0000;
            jt_rdata <= 32'h0000_0000;
            jt_pend <= 1'b0;
            jt_pw <= 1'b0;
            rd_v <= '0;
            rd_cp <= '0;
            rd_a <= '{default: '0};
            o_sram_we <= 1'b0;
            o_sram_addr <= 11'h000;
            o_sram_wdata <= 32'h0000_0000;
            o_prog_reject <= 1'b0;
            o_link_dbg_grant <= 1'b0;
            bp_hold <= 1'b0;
            o_dbg_pin_oe <= 1'b0;
            o_debug_enter <= 1'b0;
            pin_d <= 1'b1;
            o_boot_done <= 1'b0;
            o_boot_from_otp <= 1'b0;
            o_otp_redundant <= 1'b0;
            o_sec_word <= otp_sec_pkg::SEC_SAFE;
            o_dbg_pin <= 1'b0;
        end
        else
        begin
            boot <= next_boot;
            sec <= next_sec;
            o_otp <= next_otp;
            cp_addr <= next_cp_addr;
            prog_addr <= next_prog_addr;
            prog_data <= next_prog_data;
            jt_rdata <= next_jt_rdata;
            jt_pend <= next_jt_pend;
            jt_pw <= next_jt_pw;
            rd_v <= {rd_v[0], o_otp.re};
            rd_cp <= {rd_cp[0], boot == otp_sec_pkg::B_COPY || boot == otp_sec_pkg::B_DRAIN};
            rd_a <= '{o_otp.addr[otp_sec_pkg::OTP_AW-1:0], rd_a[0]};
            o_sram_we <= next_sram_we;
            o_sram_addr <= next_sram_addr;
            o_sram_wdata <= next_sram_wdata;
            o_prog_reject <= next_reject;
            o_link_dbg_grant <= next_grant;
            bp_hold <= next_bp_hold;
            o_dbg_pin_oe <= next_pin_oe;
            o_debug_enter <= next_enter;
            pin_d <= pin_s2[4];
            o_boot_done <= (next_boot == otp_sec_pkg::B_RUN);
            o_boot_from_otp <= next_sec.boot_otp;
            o_otp_redundant <= next_sec.redundant;
            o_sec_word <= next_sec;
            // Sync pin level fixed low; enable does the work
            o_dbg_pin <= 1'b0;
        end
    end

endmodule : otp_security_and_id

// File: otp_security_and_id_assertions.sv
module otp_security_and_id_assertions (
    input wire logic i_clk,
    input wire logic i_nrst,
    input wire otp_sec_pkg::otp_req_s o_otp,
    input wire logic o_boot_done,
    input wire logic o_boot_from_otp,
    input wire logic o_otp_redundant,
    input wire logic [31:0] o_sec_word,
    input wire logic i_port_we,
    input wire logic [23:0] i_port_id,
    input wire logic [31:0] i_port_wdata,
    input wire logic o_prog_reject,
    input wire logic i_link_dbg_req,
    input wire logic o_link_dbg_grant,
    input wire logic o_dbg_pin_oe,
    input wire logic i_dbg_pin_out_mode,
    input wire logic i_breakpoint,
    input wire logic o_debug_enter
);
    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (!i_nrst);
    logic [31:0] sec_q;
    always_ff @(posedge i_clk)
        sec_q <= o_sec_word;
    AST_LINK_GRANT: assert property (o_link_dbg_grant |-> $past(i_link_dbg_req) && !sec_q[1])
        else $error("link grant while blocked or unrequested");
    AST_BOOT_SRC: assert property (o_boot_done |-> o_boot_from_otp == o_sec_word[5])
        else $error("boot source differs from security word");
    AST_REDUNDANT: assert property (o_boot_done |-> o_otp_redundant == o_sec_word[7])
        else $error("redundant rows differ from security word");
    AST_MASTER_LOCK: assert property (i_port_we && i_port_id == otp_sec_pkg::PORT_ID_CTRL
        && i_port_wdata[0] && o_sec_word[12] && o_boot_done |=> o_prog_reject && !o_otp.we)
        else $error("programming not refused under master lock");
    AST_SECTOR_LOCK: assert property (o_otp.we && !o_otp.addr[11]
        |-> !sec_q[12] && !sec_q[8 + o_otp.addr[10:9]])
        else $error("locked sector written");
    AST_SEC_KEEP: assert property (o_boot_done && $past(o_boot_done) |-> (o_sec_word & sec_q) == sec_q)
        else $error("security bit cleared");
    AST_PIN_OE: assert property ($rose(o_dbg_pin_oe)
        |-> $past(i_breakpoint) && $past(i_dbg_pin_out_mode) && !sec_q[14])
        else $error("sync pin driven without breakpoint");
    AST_ENTER: assert property (o_debug_enter |-> !o_sec_word[14] && !i_dbg_pin_out_mode)
        else $error("debug entry while pin disabled or in output mode");
endmodule : otp_security_and_id_assertions

bind otp_security_and_id otp_security_and_id_assertions u_chk (.i_clk, .i_nrst, .o_otp,
    .o_boot_done, .o_boot_from_otp, .o_otp_redundant, .o_sec_word, .i_port_we, .i_port_id,
    .i_port_wdata, .o_prog_reject, .i_link_dbg_req, .o_link_dbg_grant, .o_dbg_pin_oe,
    .i_dbg_pin_out_mode, .i_breakpoint, .o_debug_enter);

// File: tb.sv
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [31:0] SEC = 32'h8040_01a2;
    logic i_clk = 0, i_nrst = 0, i_tck = 0, i_tms = 1, i_tdi = 0, i_port_we = 0;
    logic i_trst_n = 0;
    logic i_link_dbg_req = 0, i_breakpoint = 0, i_dbg_resume = 0, i_dbg_pin_out_mode = 0;
    logic host_low = 0, seen_we, seen_rej, o_sram_we, o_boot_done, o_boot_from_otp;
    logic o_otp_redundant, o_prog_reject, o_link_dbg_grant, o_dbg_pin, o_dbg_pin_oe, o_debug_enter;
    logic o_tdo, o_tdo_oe;
    logic [10:0] o_sram_addr;
    logic [23:0] i_port_id = 24'h0;
    logic [31:0] i_port_wdata = 32'h0, i_dbg_rdata = 32'h0, i_otp_rdata, o_sec_word, o_sram_wdata;
    otp_sec_pkg::otp_req_s o_otp, got;
    int miscompares = 0, check_count = 0, sram_n = 0;
    wire i_dbg_pin = o_dbg_pin_oe ? o_dbg_pin : !host_low;
    otp_security_and_id uut (.*, .o_dbg_wdata(), .o_dbg_we());
    otp_macro_model #(.SEC_VALUE(SEC)) otp (.i_clk, .i_req(o_otp), .o_rdata(i_otp_rdata));
    always #25 i_clk = ~i_clk;
    always @(negedge i_clk)
        if (o_sram_we === 1'b1)
        begin
            sram_n++;
            check(o_sram_wdata, {21'h0, o_sram_addr}, "sram copy");
        end
    // ----------------------------------------
    // Shared tasks
    // ----------------------------------------
    task automatic tick(input int n);
        repeat (n) @(posedge i_clk);
        #5;
    endtask : tick
    task automatic check(input logic [63:0] g, input logic [63:0] e, input string m);
        check_count++;
        if (g !== e)
        begin
            miscompares++;
            $display("wrong value at %0t: %s got %h expected %h", $time, m, g, e);
        end
    endtask : check
    // Test clock: low half, then high half; TDO taken just before the rise
    task automatic jt(input logic [31:0] tms, input logic [31:0] tdi, input int n,
                      output logic [31:0] q);
        for (int i = 0; i < n; i++)
        begin
            i_tck = 0;
            i_tms = tms[i];
            i_tdi = tdi[i];
            tick(4);
            q = {o_tdo, q[31:1]};
            i_tck = 1;
            tick(4);
        end
    endtask : jt
    task automatic scan_ids();
        logic [31:0] q;
        i_trst_n = 1;
        jt(32'h5f, 0, 9, q);
        jt(32'h8000_0000, 0, 32, q);
        check(q, {otp_sec_pkg::ID_VERSION, otp_sec_pkg::ID_PART, otp_sec_pkg::ID_MAKER,
            1'b1}, "scan_identification");
        jt(32'h0d, 0, 6, q);
        jt(32'h8, otp_sec_pkg::IR_USERCODE, 4, q);
        check(q[31:28], otp_sec_pkg::IR_CAPTURE, "ir capture");
        jt(32'h3, 0, 4, q);
        jt(32'h8000_0000, 0, 32, q);
        check(q, {SEC[31:22], 14'h0, otp_sec_pkg::SILICON_REV}, "usercode");
        jt(32'h1, 0, 2, q);
    endtask : scan_ids
    // Port enable held across all three writes; they are back to back
    task automatic prog(input logic [10:0] row, input logic [31:0] d, input logic [1:0] ctl);
        i_port_we = 1;
        i_port_id = otp_sec_pkg::PORT_ID_ADDR;
        i_port_wdata = {21'h0, row};
        tick(1);
        i_port_id = otp_sec_pkg::PORT_ID_DATA;
        i_port_wdata = d;
        tick(1);
        i_port_id = otp_sec_pkg::PORT_ID_CTRL;
        i_port_wdata = {30'h0, ctl};
        seen_we = 0;
        seen_rej = 0;
        repeat (3)
        begin
            tick(1);
            i_port_we = 0;
            seen_rej |= o_prog_reject;
            seen_we |= o_otp.we;
            if (o_otp.we === 1'b1) got = o_otp;
        end
    endtask : prog
    task automatic give_verdict();
        if (miscompares == 0 && check_count > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : give_verdict
    initial
    begin
        tick(10);
        i_nrst = 1;
        for (int n = 0; n < 3000 && o_boot_done !== 1'b1; n++) tick(1);
        check(o_sec_word, SEC, "sec word");
        check({o_boot_from_otp, o_otp_redundant}, 2'b11, "boot src, redundancy");
        check(sram_n, 2048, "copy count");
        scan_ids();
        prog(11'h005, 32'h1234_5678, 2'h1);
        check({seen_we, seen_rej}, 2'b01, "sector 0");
        prog(11'h205, 32'h1234_5678, 2'h1);
        check({seen_we, seen_rej}, 2'b10, "sector 1");
        check({got.addr, got.wdata}, {12'h205, 32'h1234_5678}, "otp write");
        i_link_dbg_req = 1;
        tick(2);
        check(o_link_dbg_grant, 0, "link grant");
        i_link_dbg_req = 0;
        i_dbg_pin_out_mode = 1;
        check(i_dbg_pin, 1, "pin idle");
        i_breakpoint = 1;
        tick(1);
        i_breakpoint = 0;
        tick(1);
        check(i_dbg_pin, 0, "pin on break");
        i_dbg_resume = 1;
        tick(1);
        i_dbg_resume = 0;
        i_dbg_pin_out_mode = 0;
        tick(2);
        host_low = 1;
        seen_we = 0;
        repeat (8)
        begin
            tick(1);
            seen_we |= o_debug_enter;
        end
        check(seen_we, 1, "debug entry");
        host_low = 0;
        prog(11'h0, 32'h0000_1000, 2'h3);
        check(o_sec_word, SEC | 32'h1000, "lock set");
        prog(11'h405, 32'h1, 2'h1);
        check({seen_we, seen_rej}, 2'b01, "master lock row");
        prog(11'h0, 32'h0002_0000, 2'h3);
        check({seen_rej, o_sec_word}, {1'b1, SEC | 32'h1000}, "master lock word");
        give_verdict();
    end
    initial
    begin
        tick(20000);
        miscompares++;
        give_verdict();
    end
endmodule : tb
